/* File: logic/pam_alarm_manager.sv */
// Purpose: Alarm latching, reset acceptance, output control and display ranking.
// Assumes: APB slave with one wait state; condition inputs synchronous to core_clk.
// Notes: All hold-off and stability timers share one 1 ms timebase.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pam_cfg.svh"
module pam_alarm_manager
  import pam_pkg::*;
#(
  parameter int TICK_CYCLES = `PAM_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire pam_cond_s cond,
  input wire pam_ui_s ui,
  input wire logic resetKey,
  input wire logic powerUp,
  input wire logic settingEnter,
  input wire logic [1:0] nvTrip,
  output logic [1:0] tripHold,
  output logic [3:0] branchOn,
  output logic tripIndicatorOutput,
  output logic alarmIndicatorOutput,
  output logic overtempIndicatorOutput,
  output logic runMode,
  output logic runtimeClearItem,
  output logic yesNoShown,
  output logic [7:0] dispCode,
  output logic dispShowValue
);
  localparam int NA = `PAM_NUM_ALARM;
  localparam int NM = `PAM_NUM_MANUAL;

  // ----------------------------------------------------------------
  // Timebase and reset requests
  // ----------------------------------------------------------------
  logic [17:0] tickCnt, next_tickCnt;
  logic tick, next_tick;
  logic [15:0] keyCnt, next_keyCnt;
  logic keyFire, next_keyFire;
  logic cmdReset;

  always_comb begin
    next_tick = 1'b0;
    next_tickCnt = tickCnt + 18'h00001;
    if (tickCnt == 18'(TICK_CYCLES - 1)) begin
      next_tickCnt = '0;
      next_tick = 1'b1;
    end
    next_keyCnt = keyCnt;
    next_keyFire = 1'b0;
    if (!resetKey) begin
      next_keyCnt = '0;
    end else if (tick && keyCnt != `PAM_KEY_HOLD_MS) begin
      next_keyCnt = keyCnt + 16'h0001;
      // One request per continuous hold, fired as the hold reaches 3 s.
      next_keyFire = (keyCnt + 16'h0001) == `PAM_KEY_HOLD_MS;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt <= '0;
      tick <= 1'b0;
      keyCnt <= '0;
      keyFire <= 1'b0;
    end else begin
      tickCnt <= next_tickCnt;
      tick <= next_tick;
      keyCnt <= next_keyCnt;
      keyFire <= next_keyFire;
    end
  end

  wire resetReq = keyFire | cmdReset;

  // ----------------------------------------------------------------
  // Manually reset alarms: trips, overvoltage, undervoltage, overcurrent
  // ----------------------------------------------------------------
  logic [NM-1:0] cause, okNow, isTrip;
  logic [NM-1:0] latch, next_latch, eligible;
  logic [15:0] holdCnt [NM], next_holdCnt [NM];
  logic [15:0] stabCnt [NM], next_stabCnt [NM];
  logic booted;

  always_comb begin
    cause = {cond.overCurr, cond.underVolt, cond.overVolt, cond.abnCurr, cond.abnVolt};
    okNow = {cond.overCurrGone, cond.underVoltGone, cond.overVoltGone, ~cond.abnCurr, ~cond.abnVolt};
    isTrip = 5'b00011;
    for (int i = 0; i < NM; i++) begin
      next_latch[i] = latch[i];
      next_holdCnt[i] = holdCnt[i];
      next_stabCnt[i] = stabCnt[i];
      // Hold-off runs from the moment of the alarm or cutoff.
      if (latch[i] && tick && holdCnt[i] != `PAM_HOLDOFF_MS) begin
        next_holdCnt[i] = holdCnt[i] + 16'h0001;
      end
      // The stability window only opens once the hold-off has ended.
      if (!okNow[i] || holdCnt[i] != `PAM_HOLDOFF_MS) begin
        next_stabCnt[i] = '0;
      end else if (tick && stabCnt[i] != `PAM_STABLE_MS) begin
        next_stabCnt[i] = stabCnt[i] + 16'h0001;
      end
      eligible[i] = latch[i] && holdCnt[i] == `PAM_HOLDOFF_MS &&
                    (isTrip[i] ? okNow[i] : stabCnt[i] == `PAM_STABLE_MS);
      // Ineligible requests leave the latch untouched.
      if (resetReq && eligible[i]) begin
        next_latch[i] = 1'b0;
      end
      if (powerUp && !isTrip[i] && !cause[i]) begin
        next_latch[i] = 1'b0;
      end
      if (!booted && i < 2) begin
        next_latch[i] = next_latch[i] | nvTrip[i[0]];
      end
      // A new cause always wins over a clear in the same cycle.
      if (cause[i]) begin
        next_latch[i] = 1'b1;
      end
      if (next_latch[i] && !latch[i]) begin
        next_holdCnt[i] = '0;
        next_stabCnt[i] = '0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch <= '0;
      booted <= 1'b0;
      for (int i = 0; i < NM; i++) begin
        holdCnt[i] <= '0;
        stabCnt[i] <= '0;
      end
    end else begin
      latch <= next_latch;
      booted <= 1'b1;
      for (int i = 0; i < NM; i++) begin
        holdCnt[i] <= next_holdCnt[i];
        stabCnt[i] <= next_stabCnt[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Run-time clear item and over-temperature
  // ----------------------------------------------------------------
  pam_clr_e clrState, next_clrState;
  logic rtLatch, next_rtLatch, rtClear;
  logic tmpLatch, next_tmpLatch;
  logic [15:0] tmpCnt, next_tmpCnt;
  wire itemVisible = ui.protLevel != `PAM_PROT_LOCKED;

  always_comb begin
    next_clrState = clrState;
    rtClear = 1'b0;
    unique case (clrState)
      CLR_IDLE: begin
        if (itemVisible && ui.clrItemSel && ui.modeKey) begin
          next_clrState = CLR_ASK;
        end
      end
      CLR_ASK: begin
        if (!itemVisible || !ui.clrItemSel) begin
          next_clrState = CLR_IDLE;
        end else if (ui.modeKey) begin
          rtClear = ui.yesShown;
          next_clrState = CLR_IDLE;
        end
      end
      default: next_clrState = CLR_IDLE;
    endcase
    next_rtLatch = (rtLatch && !rtClear) || cond.runTimeUp;
    next_tmpCnt = '0;
    if (cond.overTempGone && tmpLatch) begin
      next_tmpCnt = tick ? tmpCnt + 16'h0001 : tmpCnt;
    end
    next_tmpLatch = tmpLatch;
    if (next_tmpCnt == `PAM_TEMP_CLR_MS) begin
      next_tmpLatch = 1'b0;
      next_tmpCnt = '0;
    end
    if (cond.overTemp) begin
      next_tmpLatch = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clrState <= CLR_IDLE;
      rtLatch <= 1'b0;
      tmpLatch <= 1'b0;
      tmpCnt <= '0;
    end else begin
      clrState <= next_clrState;
      rtLatch <= next_rtLatch;
      tmpLatch <= next_tmpLatch;
      tmpCnt <= next_tmpCnt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, run mode and alarm display
  // ----------------------------------------------------------------
  logic [NA-1:0] alarms;
  logic [7:0] next_dispCode;
  logic [15:0] altCnt, next_altCnt;
  logic altPhase, next_altPhase;
  logic next_runMode, anyAccepted;

  always_comb begin
    alarms = {tmpLatch, rtLatch, latch};
    next_dispCode = `PAM_CODE_NONE;
    for (int i = NA - 1; i >= 0; i--) begin
      if (alarms[i]) begin
        next_dispCode = PAM_CODES[i];
      end
    end
    next_altCnt = altCnt;
    next_altPhase = altPhase;
    if (alarms == '0) begin
      next_altCnt = '0;
      next_altPhase = 1'b0;
    end else if (tick) begin
      next_altCnt = altCnt + 16'h0001;
      if (next_altCnt == `PAM_DISP_ALT_MS) begin
        next_altCnt = '0;
        next_altPhase = ~altPhase;
      end
    end
    anyAccepted = (resetReq && (eligible != '0)) || rtClear;
    next_runMode = runMode;
    if (settingEnter) begin
      next_runMode = 1'b0;
    end
    if (anyAccepted) begin
      next_runMode = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dispCode <= `PAM_CODE_NONE;
      altCnt <= '0;
      altPhase <= 1'b0;
      dispShowValue <= 1'b0;
      runMode <= 1'b1;
      tripHold <= '0;
      branchOn <= '0;
      tripIndicatorOutput <= 1'b0;
      alarmIndicatorOutput <= 1'b0;
      overtempIndicatorOutput <= 1'b0;
      runtimeClearItem <= 1'b0;
      yesNoShown <= 1'b0;
    end else begin
      dispCode <= next_dispCode;
      altCnt <= next_altCnt;
      altPhase <= next_altPhase;
      dispShowValue <= next_altPhase;
      runMode <= next_runMode;
      tripHold <= next_latch[1:0];
      branchOn <= {4{~|next_latch[1:0]}};
      tripIndicatorOutput <= ~|next_latch[1:0];
      alarmIndicatorOutput <= ~(|next_latch[4:2] | next_rtLatch);
      overtempIndicatorOutput <= ~next_tmpLatch;
      runtimeClearItem <= itemVisible;
      yesNoShown <= next_clrState == CLR_ASK;
    end
  end

  // ----------------------------------------------------------------
  // APB slave and interrupt
  // ----------------------------------------------------------------
  logic [NA-1:0] status, next_status, enable, next_enable, prevAlarms;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq, mapped;
  wire wrDone = psel && penable && pready && pwrite;

  always_comb begin
    unique case (paddr)
      `PAM_ADDR_ALARM: begin
        mapped = 1'b1;
        next_prdata = {17'h00000, dispCode, alarms};
      end
      `PAM_ADDR_STATUS: begin
        mapped = 1'b1;
        next_prdata = {25'h0000000, status};
      end
      `PAM_ADDR_ENABLE: begin
        mapped = 1'b1;
        next_prdata = {25'h0000000, enable};
      end
      `PAM_ADDR_CLEAR, `PAM_ADDR_CMD: begin
        mapped = 1'b1;
        next_prdata = '0;
      end
      default: begin
        mapped = 1'b0;
        next_prdata = '0;
      end
    endcase
    next_pready = psel && penable && !pready;
    next_pslverr = next_pready && !mapped;
    cmdReset = wrDone && paddr == `PAM_ADDR_CMD && pwdata[`PAM_CMD_RESET];
    next_enable = enable;
    if (wrDone && paddr == `PAM_ADDR_ENABLE) begin
      next_enable = pwdata[NA-1:0];
    end
    next_status = status;
    if (wrDone && paddr == `PAM_ADDR_CLEAR) begin
      next_status = status & ~pwdata[NA-1:0];
    end
    // New alarm events set status after the clear, so none is lost.
    next_status = next_status | (alarms & ~prevAlarms);
    next_irq = |(next_status & next_enable);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      status <= '0;
      enable <= '0;
      prevAlarms <= '0;
    end else begin
      prdata <= next_pready ? next_prdata : '0;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
      status <= next_status;
      enable <= next_enable;
      prevAlarms <= alarms;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_trip_cuts_power: assert property (cond.abnVolt |=> branchOn == 4'h0 && !tripIndicatorOutput)
    else $error("Trip did not cut power.");
  a_alarm_keeps_power: assert property ((cond.overVolt || cond.underVolt || cond.overCurr) && latch[1:0] == 2'b00
    && !cond.abnVolt && !cond.abnCurr |=> !alarmIndicatorOutput && branchOn == 4'hf)
    else $error("Voltage or current alarm misdriven.");
  a_temp_self_clear: assert property (tmpLatch && !cond.overTemp && tmpCnt == `PAM_TEMP_CLR_MS - 16'h0001
    && tick && cond.overTempGone |=> !tmpLatch)
    else $error("Overtemp not self cleared.");
  a_key_hold_fire: assert property ($rose(keyFire) |-> $past(keyCnt) == `PAM_KEY_HOLD_MS - 16'h0001)
    else $error("Key request before 3 s.");
  a_holdoff_guard: assert property (latch[0] && holdCnt[0] != `PAM_HOLDOFF_MS |=> latch[0])
    else $error("Trip reset inside hold-off.");
  a_stable_guard: assert property (latch[2] && stabCnt[2] != `PAM_STABLE_MS && !powerUp |=> latch[2])
    else $error("Overvoltage reset before stable window.");
  a_reconnect: assert property ($fell(latch[1:0] != 2'b00) |-> ##1 branchOn == 4'hf)
    else $error("Power not reconnected.");
  a_run_return: assert property (resetReq && eligible != '0 && !settingEnter |=> runMode)
    else $error("Run mode not resumed.");
  a_clear_hidden: assert property (ui.protLevel == `PAM_PROT_LOCKED |-> !rtClear)
    else $error("Run-time cleared while hidden.");
  a_prio_top: assert property (latch[0] |=> dispCode == PAM_CODES[0])
    else $error("Display priority wrong.");
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("APB answer late.");
endmodule : pam_alarm_manager
`default_nettype wire

/* File: shared/pam_cfg.svh */
// Purpose: Named constants of the protector alarm manager.
// Assumes: A 250 MHz core clock and a 1 ms timebase tick.
// Notes: Times are in their own unit; cycle counts derive from them.
`ifndef PAM_CFG_SVH
`define PAM_CFG_SVH
`define PAM_CLK_PERIOD_NS 4
`define PAM_TICK_NS 1000000
`define PAM_TICK_CYCLES (`PAM_TICK_NS / `PAM_CLK_PERIOD_NS)
`define PAM_KEY_HOLD_MS 16'd3000
`define PAM_HOLDOFF_MS 16'd15000
`define PAM_STABLE_MS 16'd500
`define PAM_TEMP_CLR_MS 16'd5000
`define PAM_DISP_ALT_MS 16'd1000
`define PAM_ADDR_ALARM 12'h000
`define PAM_ADDR_STATUS 12'h004
`define PAM_ADDR_CLEAR 12'h008
`define PAM_ADDR_ENABLE 12'h00c
`define PAM_ADDR_CMD 12'h010
`define PAM_CMD_RESET 0
`define PAM_NUM_ALARM 7
`define PAM_NUM_MANUAL 5
`define PAM_IDX_A10 0
`define PAM_IDX_A11 1
`define PAM_IDX_A20 2
`define PAM_IDX_A21 3
`define PAM_IDX_A22 4
`define PAM_IDX_A23 5
`define PAM_IDX_A30 6
`define PAM_PROT_LOCKED 2'h2
`define PAM_CODE_NONE 8'h00
`endif

/* File: shared/pam_pkg.sv */
// Purpose: Types shared by the protector alarm manager.
// Assumes: Condition inputs come from comparators already synchronous to core_clk.
// Notes: Alarm codes are the displayed numbers in two hex digits.
package pam_pkg;
  typedef struct packed {
    logic abnVolt;
    logic abnCurr;
    logic overVolt;
    logic overVoltGone;
    logic underVolt;
    logic underVoltGone;
    logic overCurr;
    logic overCurrGone;
    logic runTimeUp;
    logic overTemp;
    logic overTempGone;
  } pam_cond_s;
  typedef struct packed {
    logic [1:0] protLevel;
    logic clrItemSel;
    logic modeKey;
    logic yesShown;
  } pam_ui_s;
  typedef enum logic [1:0] {
    CLR_IDLE = 2'b01,
    CLR_ASK = 2'b10
  } pam_clr_e;
  typedef logic [7:0] pam_code_t;
  localparam pam_code_t PAM_CODES [0:6] = '{8'h10, 8'h11, 8'h20, 8'h21, 8'h22, 8'h23, 8'h30};
endpackage : pam_pkg

/* File: tb/pam_panel_model.sv */
// Purpose: Front-panel reset key as the operator works it.
// Assumes: One press request at a time; the bench waits for busy to fall.
// Notes: A released key reads low and a held key reads high.
`timescale 1ns/10ps
`default_nettype none
module pam_panel_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic press,
  input var int holdCycles,
  output logic resetKey,
  output logic busy
);
  int cnt;
  // The key is held without a break, so any gap would restart the hold count.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      resetKey <= 1'b0;
    end else if (press) begin
      resetKey <= 1'b1;
      cnt <= holdCycles;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      cnt <= 0;
      resetKey <= 1'b0;
    end
  end
  assign busy = resetKey;
endmodule : pam_panel_model
`default_nettype wire

/* File: tb/protector_alarm_manager_bench.sv */
// Purpose: Self-checking bench of the alarm manager.
// Assumes: A timebase tick of two clock cycles.
// Notes: The serial reset command is written through APB.
`timescale 1ns/10ps
`default_nettype none
`include "pam_cfg.svh"
module protector_alarm_manager_bench;
  import pam_pkg::*;
  localparam int TC = 2;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, resetKey, powerUp = 1'b0, settingEnter = 1'b0, press = 1'b0, busy, err;
  pam_cond_s cond = '0;
  pam_ui_s ui = '0;
  logic [1:0] nvTrip = 2'h0, tripHold;
  logic [3:0] branchOn;
  logic tripInd, almInd, tmpInd, runMode, clrItem, yesNo, showVal;
  logic [7:0] dispCode;
  int holdCycles = 0, fails = 0, n_tests = 0, cyc = 0;
  always #2 core_clk = ~core_clk;
  pam_alarm_manager #(.TICK_CYCLES(TC)) pam_alarm_manager_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .cond(cond), .ui(ui), .resetKey(resetKey), .powerUp(powerUp),
    .settingEnter(settingEnter), .nvTrip(nvTrip), .tripHold(tripHold), .branchOn(branchOn),
    .tripIndicatorOutput(tripInd), .alarmIndicatorOutput(almInd), .overtempIndicatorOutput(tmpInd),
    .runMode(runMode), .runtimeClearItem(clrItem), .yesNoShown(yesNo), .dispCode(dispCode),
    .dispShowValue(showVal));
  pam_panel_model pam_panel_model_i (.core_clk(core_clk), .rst_n(rst_n), .press(press),
    .holdCycles(holdCycles), .resetKey(resetKey), .busy(busy));
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      fails++;
      stop_test();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n * TC) @(posedge core_clk);
  endtask : tick
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_n
  task automatic test_idle();
    chk({branchOn, tripInd, almInd, tmpInd, runMode}, 8'hff);
    apb(1'b1, `PAM_ADDR_ENABLE, 32'h7f);
    apb(1'b0, `PAM_ADDR_ENABLE, 0);
    chk(rd, 32'h7f);
    apb(1'b0, 12'h0f0, 0);
    chk({err, rd}, 33'h100000000);
    $display("test idle done");
  endtask : test_idle
  task automatic test_trip_cmd();
    cond.abnVolt <= 1'b1;
    cond.overVolt <= 1'b1;
    cond.overCurr <= 1'b1;
    wait_n(4);
    chk({branchOn, tripInd, almInd, tmpInd}, 7'h01);
    chk(dispCode, 8'h10);
    apb(1'b0, `PAM_ADDR_ALARM, 0);
    chk(rd, 32'h815);
    apb(1'b0, `PAM_ADDR_STATUS, 0);
    chk({irq, rd[6:0]}, 8'h95);
    cond <= pam_cond_s'{overVoltGone: 1'b1, default: 1'b0};
    apb(1'b1, `PAM_ADDR_CMD, 32'h1);
    wait_n(4);
    chk({branchOn, tripInd}, 5'h00);
    tick(15400);
    cond.overCurrGone <= 1'b1;
    tick(200);
    apb(1'b1, `PAM_ADDR_CMD, 32'h1);
    wait_n(4);
    chk({branchOn, tripInd, almInd, runMode}, 7'h7d);
    chk(dispCode, 8'h22);
    tick(400);
    apb(1'b1, `PAM_ADDR_CMD, 32'h1);
    wait_n(4);
    chk({almInd, runMode, dispCode}, 10'h300);
    apb(1'b1, `PAM_ADDR_CLEAR, 32'h7f);
    apb(1'b0, `PAM_ADDR_STATUS, 0);
    wait_n(2);
    chk({irq, rd}, 33'h0);
    $display("test trip by command done");
  endtask : test_trip_cmd
  task automatic test_temp_power();
    cond <= pam_cond_s'{underVolt: 1'b1, overTemp: 1'b1, default: 1'b0};
    wait_n(4);
    chk({branchOn, almInd, tmpInd}, 6'h3c);
    cond.underVolt <= 1'b0;
    powerUp <= 1'b1;
    @(posedge core_clk);
    powerUp <= 1'b0;
    wait_n(4);
    chk(almInd, 1'b1);
    cond.overTemp <= 1'b0;
    cond.overTempGone <= 1'b1;
    tick(4900);
    chk(tmpInd, 1'b0);
    tick(200);
    chk(tmpInd, 1'b1);
    cond.overTempGone <= 1'b0;
    $display("test temperature and power done");
  endtask : test_temp_power
  task automatic mode_key();
    ui.modeKey <= 1'b1;
    @(posedge core_clk);
    ui.modeKey <= 1'b0;
    wait_n(4);
  endtask : mode_key
  task automatic test_runtime();
    settingEnter <= 1'b1;
    cond.runTimeUp <= 1'b1;
    @(posedge core_clk);
    settingEnter <= 1'b0;
    wait_n(4);
    cond.runTimeUp <= 1'b0;
    chk({runMode, almInd, dispCode}, 10'h023);
    apb(1'b1, `PAM_ADDR_CMD, 32'h1);
    ui.protLevel <= 2'h2;
    ui.clrItemSel <= 1'b1;
    wait_n(4);
    chk({almInd, clrItem}, 2'h0);
    mode_key();
    chk(yesNo, 1'b0);
    ui.protLevel <= 2'h1;
    wait_n(4);
    chk(clrItem, 1'b1);
    mode_key();
    chk(yesNo, 1'b1);
    ui.yesShown <= 1'b1;
    mode_key();
    chk({almInd, runMode}, 2'h3);
    ui <= '0;
    $display("test run time clear done");
  endtask : test_runtime
  task automatic key(input int ticks);
    int k;
    k = 0;
    holdCycles <= ticks * TC;
    press <= 1'b1;
    @(posedge core_clk);
    press <= 1'b0;
    wait_n(2);
    while (busy === 1'b1 && k < 8000) begin
      @(posedge core_clk);
      k++;
    end
    wait_n(4);
  endtask : key
  task automatic test_restore_key();
    int toggles;
    logic last;
    toggles = 0;
    rst_n <= 1'b0;
    nvTrip <= 2'h2;
    wait_n(2);
    rst_n <= 1'b1;
    wait_n(4);
    chk({tripHold, branchOn, tripInd, dispCode}, 15'h4011);
    powerUp <= 1'b1;
    @(posedge core_clk);
    powerUp <= 1'b0;
    wait_n(4);
    chk({branchOn, tripInd}, 5'h00);
    last = showVal;
    repeat (2500 * TC) begin
      @(posedge core_clk);
      if (showVal !== last) toggles++;
      last = showVal;
    end
    chk(toggles >= 2 && toggles <= 3, 1'b1);
    tick(12700);
    key(2000);
    chk(branchOn, 4'h0);
    key(3100);
    chk({tripHold, branchOn, tripInd, runMode}, 8'h3f);
    $display("test restored trip and key reset done");
  endtask : test_restore_key
  initial begin
    wait_n(2);
    rst_n <= 1'b1;
    wait_n(2);
    test_idle();
    test_trip_cmd();
    test_temp_power();
    test_runtime();
    test_restore_key();
    stop_test();
  end
endmodule : protector_alarm_manager_bench
`default_nettype wire
